// ### design/ccrb_regs.sv
// runtime config and region base control registers
//
// Operation
// - nested mode 0: clear previous irq enable on every interrupt taken.
// - nested mode 1: keep previous irq enable at one on interrupt.
// - without irq controller port and shadow sets, nested mode reads zero.
// - trap enable 1: raise exception on each detected ecc error.
// - ecc enable 0: correct no detected ecc error; trap enable still applies.
// - ecc enable 1: correct every recoverable ecc error.
// - guard enable bit switches region guard unit on or off.
// - without a region guard unit, guard enable reads zero.
// - config is not saved or restored on exception entry or return.
// - region base register exists only with the region guard unit.
// - base field maps address bits 8..31; bases align to 256 bytes.
// - low base bits below minimum region size read zero.
// - high base bits beyond address width read zero.
// - index and data select choose the entry for region operations.
// - data select 1 means data region, 0 instruction region.
// - index picks one of 32 regions; unused high bits read zero.
// - attribute write with read flag loads, with write flag stores region.
`timescale 1ns/1ns
`default_nettype none
module ccrb_regs
  import ccrb_pkg::*;
#(
  parameter bit HAS_GUARD     = 1'b1,
  parameter bit HAS_NEST      = 1'b1,
  parameter bit HAS_ECC       = 1'b1,
  parameter int MIN_REGION    = 256,
  parameter int ADDR_BITS     = 32,
  parameter int NUM_REGIONS   = 32
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control-register port
  input  wire logic        ctl_wr_en,
  input  wire logic [4:0]  ctl_num,
  input  wire logic [31:0] ctl_wr_data,
  output logic [31:0]      ctl_rd_data,
  // interrupt and exception events
  input  wire logic        irq_taken,
  input  wire logic        prev_irq_enable_in,
  output logic             prev_irq_enable_next,
  input  wire logic        ecc_error,
  input  wire logic        ecc_recoverable,
  output logic             ecc_trap,
  output logic             ecc_fix,
  // region guard controls
  output logic             region_guard_enable,
  output logic             region_sel_data,
  output logic [4:0]       region_index,
  output logic [23:0]      region_base,
  output logic             region_load,
  output logic             region_store
);
  import ccrb_pkg::*;

  // ==========================================================
  // implemented-bit masks
  localparam int LOW_BITS  = $clog2(MIN_REGION) - 8;
  localparam int HIGH_BITS = ADDR_BITS - BASE_ADDR_LSB;
  localparam int IDX_BITS  = (NUM_REGIONS > 1) ? $clog2(NUM_REGIONS) : 1;

  logic [23:0] base_mask;
  logic [4:0]  idx_mask;

  ccrb_field_mask #(.W(BASE_ADDR_W), .LOW(LOW_BITS), .HIGH(HIGH_BITS))
    u_base_mask (.mask(base_mask));
  ccrb_field_mask #(.W(BASE_IDX_W), .LOW(0), .HIGH(IDX_BITS))
    u_idx_mask (.mask(idx_mask));

  localparam logic [3:0] CFG_MASK = {HAS_ECC, HAS_ECC, HAS_NEST, HAS_GUARD};

  // ==========================================================
  // write decode
  function automatic logic hit(input logic [4:0] num,
                               input logic [4:0] want);
    hit = (num == want);
  endfunction

  wire cfg_wr  = ctl_wr_en && hit(ctl_num, CFG_REG_NUM);
  wire base_wr = ctl_wr_en && hit(ctl_num, BASE_REG_NUM) && HAS_GUARD;

  // ==========================================================
  // registers
  logic [3:0]  cfg;
  logic [23:0] base_addr;
  logic [4:0]  base_idx;
  logic        base_sel;

  // unimplemented bits never store, so they read zero
  wire [3:0]  next_cfg       =
    ctl_wr_data[CFG_WIDTH-1:0] & CFG_MASK;
  wire [23:0] next_base_addr =
    ctl_wr_data[BASE_ADDR_LSB +: BASE_ADDR_W] & base_mask;
  wire [4:0]  next_base_idx  =
    ctl_wr_data[BASE_IDX_LSB +: BASE_IDX_W] & idx_mask;

  // config is only touched by writes, never by exception entry or return
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      base_addr <= BASE_ADDR_RESET;
      base_idx  <= BASE_IDX_RESET;
      base_sel  <= BASE_SEL_RESET;
    end else if (base_wr) begin
      base_addr <= next_base_addr;
      base_idx  <= next_base_idx;
      base_sel  <= ctl_wr_data[BASE_SEL_BIT];
    end
  end

  // ==========================================================
  // read mux
  wire [31:0] cfg_rd  = {28'h0000000, cfg};
  wire [31:0] base_rd = HAS_GUARD ?
    {base_addr, 2'h0, base_idx, base_sel} : 32'h00000000;
  assign ctl_rd_data = hit(ctl_num, CFG_REG_NUM)  ? cfg_rd  :
                       hit(ctl_num, BASE_REG_NUM) ? base_rd : 32'h00000000;

  // ==========================================================
  // behaviour steered by config
  wire nest_keep = cfg[CFG_NEST_BIT];
  wire ecc_on    = cfg[CFG_ECC_BIT];
  wire trap_on   = cfg[CFG_TRAP_BIT];

  assign prev_irq_enable_next = irq_taken ? nest_keep
                                          : prev_irq_enable_in;
  // trap enable acts on detection regardless of correction
  assign ecc_trap = ecc_error && trap_on;
  assign ecc_fix  = ecc_error && ecc_on && ecc_recoverable;
  assign region_guard_enable = cfg[CFG_GUARD_BIT];

  // ==========================================================
  // region selection for the attribute operations
  assign region_sel_data = base_sel;
  assign region_index    = base_idx;
  assign region_base     = base_addr;

  logic op_load;
  logic op_store;
  ccrb_region_op u_op (
    .wr_en    (ctl_wr_en),
    .wr_num   (ctl_num),
    .wr_data  (ctl_wr_data),
    .op_load  (op_load),
    .op_store (op_store)
  );
  assign region_load  = op_load  && HAS_GUARD;
  assign region_store = op_store && HAS_GUARD;

  // ==========================================================
  // checks
  property p_nest_clear;
    @(posedge clk) disable iff (!rst_n)
      (irq_taken && !cfg[CFG_NEST_BIT]) |-> !prev_irq_enable_next;
  endproperty
  a_nest_clear: assert property (p_nest_clear)
    else $error("previous irq enable not cleared");

  property p_nest_keep;
    @(posedge clk) disable iff (!rst_n)
      (irq_taken && cfg[CFG_NEST_BIT]) |-> prev_irq_enable_next;
  endproperty
  a_nest_keep: assert property (p_nest_keep)
    else $error("previous irq enable not kept");

  property p_trap;
    @(posedge clk) disable iff (!rst_n)
      (ecc_error && cfg[CFG_TRAP_BIT]) |-> ecc_trap;
  endproperty
  a_trap: assert property (p_trap)
    else $error("ecc trap missing");

  property p_ignore;
    @(posedge clk) disable iff (!rst_n)
      !cfg[CFG_ECC_BIT] |-> !ecc_fix;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("ecc fix while disabled");

  property p_cfg_persist;
    @(posedge clk) disable iff (!rst_n)
      (!cfg_wr && irq_taken) |=> $stable(cfg_rd);
  endproperty
  a_cfg_persist: assert property (p_cfg_persist)
    else $error("config changed without a write");

  property p_cfg_write;
    @(posedge clk) disable iff (!rst_n)
      cfg_wr |=> (region_guard_enable ==
                  ($past(ctl_wr_data[CFG_GUARD_BIT]) && HAS_GUARD));
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("guard enable did not follow write");

  property p_base_zero;
    @(posedge clk) disable iff (!rst_n)
      (region_base & ~base_mask) == 24'h000000;
  endproperty
  a_base_zero: assert property (p_base_zero)
    else $error("unused base bits not zero");

  property p_idx_zero;
    @(posedge clk) disable iff (!rst_n)
      base_wr |=> (region_index == ($past(ctl_wr_data[5:1]) & idx_mask));
  endproperty
  a_idx_zero: assert property (p_idx_zero)
    else $error("index not written as masked");

  property p_base_rd;
    @(posedge clk) disable iff (!rst_n)
      (HAS_GUARD && hit(ctl_num, BASE_REG_NUM)) |->
        (ctl_rd_data[7:6] == 2'b00 && ctl_rd_data[0] == region_sel_data);
  endproperty
  a_base_rd: assert property (p_base_rd)
    else $error("base readback layout wrong");

  property p_store;
    @(posedge clk) disable iff (!rst_n)
      (ctl_wr_en && ctl_num == ACC_REG_NUM && ctl_wr_data[ACC_WR_BIT]
       && HAS_GUARD) |-> region_store;
  endproperty
  a_store: assert property (p_store)
    else $error("region store strobe missing");

  // ==========================================================
  // checks on strobes, stored fields and absent build options
  property p_load;
    @(posedge clk) disable iff (!rst_n)
      (ctl_wr_en && ctl_num == ACC_REG_NUM && ctl_wr_data[ACC_RD_BIT]
       && HAS_GUARD) |-> region_load;
  endproperty
  a_load: assert property (p_load)
    else $error("region load strobe missing");

  // a stray strobe would overwrite a region entry behind software's back
  property p_no_op;
    @(posedge clk) disable iff (!rst_n)
      !(ctl_wr_en && ctl_num == ACC_REG_NUM) |->
        (!region_load && !region_store);
  endproperty
  a_no_op: assert property (p_no_op)
    else $error("region strobe without attribute write");

  property p_fix;
    @(posedge clk) disable iff (!rst_n)
      (ecc_error && ecc_recoverable && cfg[CFG_ECC_BIT]) |-> ecc_fix;
  endproperty
  a_fix: assert property (p_fix)
    else $error("recoverable ecc error not corrected");

  property p_trap_cause;
    @(posedge clk) disable iff (!rst_n)
      ecc_trap |-> ecc_error;
  endproperty
  a_trap_cause: assert property (p_trap_cause)
    else $error("ecc trap without an error");

  property p_nest_absent;
    @(posedge clk) disable iff (!rst_n)
      (!HAS_NEST && hit(ctl_num, CFG_REG_NUM)) |-> !ctl_rd_data[CFG_NEST_BIT];
  endproperty
  a_nest_absent: assert property (p_nest_absent)
    else $error("nested mode reads one without support");

  property p_guard_absent;
    @(posedge clk) disable iff (!rst_n)
      !HAS_GUARD |-> !region_guard_enable;
  endproperty
  a_guard_absent: assert property (p_guard_absent)
    else $error("guard enable set without guard unit");

  property p_base_absent;
    @(posedge clk) disable iff (!rst_n)
      (!HAS_GUARD && hit(ctl_num, BASE_REG_NUM)) |-> ctl_rd_data == '0;
  endproperty
  a_base_absent: assert property (p_base_absent)
    else $error("region base reads nonzero without guard unit");

  property p_cfg_reserved;
    @(posedge clk) disable iff (!rst_n)
      hit(ctl_num, CFG_REG_NUM) |-> ctl_rd_data[31:CFG_WIDTH] == '0;
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved)
    else $error("reserved config bits not zero");

  property p_unmapped;
    @(posedge clk) disable iff (!rst_n)
      !(hit(ctl_num, CFG_REG_NUM) || hit(ctl_num, BASE_REG_NUM)) |->
        ctl_rd_data == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped register reads nonzero");

  property p_sel_write;
    @(posedge clk) disable iff (!rst_n)
      base_wr |=> (region_sel_data == $past(ctl_wr_data[BASE_SEL_BIT]));
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("data select did not follow write");

  property p_base_hold;
    @(posedge clk) disable iff (!rst_n)
      !base_wr |=> ($stable(region_base) && $stable(region_index)
                    && $stable(region_sel_data));
  endproperty
  a_base_hold: assert property (p_base_hold)
    else $error("region selection changed without a write");

  property p_cfg_hold;
    @(posedge clk) disable iff (!rst_n)
      !cfg_wr |=> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config moved without a write");

  property p_nest_write;
    @(posedge clk) disable iff (!rst_n)
      cfg_wr |=> (cfg[CFG_NEST_BIT] ==
                  ($past(ctl_wr_data[CFG_NEST_BIT]) && HAS_NEST));
  endproperty
  a_nest_write: assert property (p_nest_write)
    else $error("nested mode did not follow write");

  property p_base_field;
    @(posedge clk) disable iff (!rst_n)
      (HAS_GUARD && hit(ctl_num, BASE_REG_NUM)) |->
        (ctl_rd_data[31:BASE_ADDR_LSB] == region_base);
  endproperty
  a_base_field: assert property (p_base_field)
    else $error("base field not at address bits 8 to 31");

endmodule
`default_nettype wire

// ### design/ccrb_pkg.sv
// package: constants for the runtime config and region base registers
package ccrb_pkg;
  // control register numbers as seen by the control-register port
  localparam logic [4:0]  CFG_REG_NUM      = 5'h0d;
  localparam logic [4:0]  BASE_REG_NUM     = 5'h0e;
  localparam logic [4:0]  ACC_REG_NUM      = 5'h0f;
  // runtime config field positions
  localparam int          CFG_GUARD_BIT    = 0;
  localparam int          CFG_NEST_BIT     = 1;
  localparam int          CFG_ECC_BIT      = 2;
  localparam int          CFG_TRAP_BIT     = 3;
  localparam int          CFG_WIDTH        = 4;
  localparam logic [3:0]  CFG_RESET        = 4'h0;
  // region base field positions
  localparam int          BASE_SEL_BIT     = 0;
  localparam int          BASE_IDX_LSB     = 1;
  localparam int          BASE_IDX_W       = 5;
  localparam int          BASE_ADDR_LSB    = 8;
  localparam int          BASE_ADDR_W      = 24;
  localparam logic [23:0] BASE_ADDR_RESET  = 24'h000000;
  localparam logic [4:0]  BASE_IDX_RESET   = 5'h00;
  localparam logic        BASE_SEL_RESET   = 1'b0;
  // region attribute register flags
  localparam int          ACC_WR_BIT       = 0;
  localparam int          ACC_RD_BIT       = 1;
  // minimum region granule in bytes
  localparam int          MIN_GRANULE      = 256;
  localparam int          FULL_ADDR_BITS   = 32;
  localparam int          MAX_REGIONS      = 32;
endpackage

// ### design/ccrb_field_mask.sv
// field mask generator: which bits of an implemented field exist
`timescale 1ns/1ns
`default_nettype none
module ccrb_field_mask #(
  parameter int W    = 24,
  parameter int LOW  = 0,
  parameter int HIGH = 24
) (
  output logic [W-1:0] mask
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign mask[g] = (g >= LOW) && (g < HIGH);
    end
  endgenerate
endmodule
`default_nettype wire

// ### design/ccrb_region_op.sv
// region operation decoder: turns an attribute write into read/write strobes
`timescale 1ns/1ns
`default_nettype none
module ccrb_region_op
  import ccrb_pkg::*;
(
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_num,
  input  wire logic [31:0] wr_data,
  output logic             op_load,
  output logic             op_store
);
  wire acc_hit = wr_en && (wr_num == ACC_REG_NUM);
  assign op_load  = acc_hit && wr_data[ACC_RD_BIT];
  assign op_store = acc_hit && wr_data[ACC_WR_BIT];
endmodule
`default_nettype wire

// ### verification/cpu_config_and_region_base_regs_bench.sv
// self-checking bench for the runtime config and region base registers
`timescale 1ns/1ns
`default_nettype none
module cpu_config_and_region_base_regs_bench;
  import ccrb_pkg::*;
  // ==========================================================
  // narrowed build: 1 KB granule, 30-bit space, 16 regions, so
  // dropped low/high base bits and the top index bit show up
  localparam logic [31:0] BASE_MASK = 32'h3ffffc1f;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ctl_wr_en = 1'b0;
  logic [4:0]  ctl_num = 5'h00;
  logic [31:0] ctl_wr_data = 32'h0;
  logic [31:0] ctl_rd_data;
  logic        irq_taken = 1'b0;
  logic        prev_in = 1'b0;
  logic        prev_next;
  logic        ecc_error = 1'b0;
  logic        ecc_rec = 1'b0;
  logic        ecc_trap;
  logic        ecc_fix;
  logic        guard_en;
  logic        sel_data;
  logic [4:0]  index;
  logic [23:0] base;
  logic        load;
  logic        store;
  logic [31:0] min_rd;
  logic        min_prev;
  logic        min_trap;
  logic        min_fix;
  logic        min_guard;
  logic        min_load;
  logic        min_store;
  logic [31:0] m_cfg = 32'h0;
  logic [31:0] m_base = 32'h0;
  logic [4:0]  nums [4] = '{CFG_REG_NUM, BASE_REG_NUM, ACC_REG_NUM, 5'h03};
  integer      seed = 99;
  integer      err_count = 0;
  integer      comparisons = 0;
  always #5 clk = ~clk;
  ccrb_regs #(.MIN_REGION(1024), .ADDR_BITS(30), .NUM_REGIONS(16)) DUT (
    .clk(clk), .rst_n(rst_n), .ctl_wr_en(ctl_wr_en), .ctl_num(ctl_num),
    .ctl_wr_data(ctl_wr_data), .ctl_rd_data(ctl_rd_data),
    .irq_taken(irq_taken), .prev_irq_enable_in(prev_in),
    .prev_irq_enable_next(prev_next), .ecc_error(ecc_error),
    .ecc_recoverable(ecc_rec), .ecc_trap(ecc_trap), .ecc_fix(ecc_fix),
    .region_guard_enable(guard_en), .region_sel_data(sel_data),
    .region_index(index), .region_base(base), .region_load(load),
    .region_store(store));
  // bare build: no guard unit, no nested mode, no ecc
  ccrb_regs #(.HAS_GUARD(1'b0), .HAS_NEST(1'b0), .HAS_ECC(1'b0)) dut_bare (
    .clk(clk), .rst_n(rst_n), .ctl_wr_en(ctl_wr_en), .ctl_num(ctl_num),
    .ctl_wr_data(ctl_wr_data), .ctl_rd_data(min_rd),
    .irq_taken(irq_taken), .prev_irq_enable_in(prev_in),
    .prev_irq_enable_next(min_prev), .ecc_error(ecc_error),
    .ecc_recoverable(ecc_rec), .ecc_trap(min_trap), .ecc_fix(min_fix),
    .region_guard_enable(min_guard), .region_sel_data(),
    .region_index(), .region_base(), .region_load(min_load),
    .region_store(min_store));
  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  // expected strobe of an attribute write for flag bit fb
  function automatic logic exp_strobe(input logic [4:0]  num,
                                      input logic [31:0] data,
                                      input int          fb);
    return num == ACC_REG_NUM && data[fb];
  endfunction
  function automatic logic exp_prev(input logic irq, input logic keep,
                                    input logic prev);
    return irq ? keep : prev;
  endfunction
  // strobes are combinational, so they are looked at before the edge;
  // the write strobe stays up so back-to-back writes never drop it
  task automatic wr(input logic [4:0] num, input logic [31:0] data);
    ctl_wr_en = 1'b1;
    ctl_num = num;
    ctl_wr_data = data;
    #1;
    chk1("load", exp_strobe(num, data, ACC_RD_BIT), load);
    chk1("store", exp_strobe(num, data, ACC_WR_BIT), store);
    chk1("bare load", 1'b0, min_load);
    chk1("bare store", 1'b0, min_store);
    @(posedge clk);
    #1;
    if (num == CFG_REG_NUM) m_cfg = data & 32'hf;
    if (num == BASE_REG_NUM) m_base = data & BASE_MASK;
  endtask
  task automatic check_all;
    ctl_wr_en = 1'b0;
    ctl_num = CFG_REG_NUM;
    #1;
    chk("config", m_cfg, ctl_rd_data);
    chk("bare config", 32'h0, min_rd);
    ctl_num = BASE_REG_NUM;
    #1;
    chk("base reg", m_base, ctl_rd_data);
    chk("bare base reg", 32'h0, min_rd);
    chk1("guard", m_cfg[0], guard_en);
    chk1("bare guard", 1'b0, min_guard);
    chk1("sel", m_base[0], sel_data);
    chk("index", {27'h0, m_base[5:1]}, {27'h0, index});
    chk("base", {8'h0, m_base[31:8]}, {8'h0, base});
    ctl_num = 5'h03;
    #1;
    chk("unmapped", 32'h0, ctl_rd_data);
  endtask
  // the event outputs follow the stored config with no delay
  task automatic ev;
    {irq_taken, prev_in, ecc_error, ecc_rec} = 4'($random(seed));
    #1;
    chk1("prev next", exp_prev(irq_taken, m_cfg[1], prev_in),
         prev_next);
    chk1("bare prev", exp_prev(irq_taken, 1'b0, prev_in), min_prev);
    chk1("trap", ecc_error & m_cfg[3], ecc_trap);
    chk1("fix", ecc_error & m_cfg[2] & ecc_rec, ecc_fix);
    chk("bare ecc", 32'h0, {30'h0, min_trap, min_fix});
    @(posedge clk);
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog: the sequence needs well under the 20000 cycles allowed
  initial begin
    #200000;
    err_count++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check_all();
    ev();
    $display("test reset values done");
    wr(CFG_REG_NUM, 32'hffffffff);
    wr(BASE_REG_NUM, 32'hffffffff);
    check_all();
    ev();
    for (int i = 0; i < 4; i++) begin
      wr(ACC_REG_NUM, i);
    end
    check_all();
    $display("test corners done");
    for (int i = 0; i < 60; i++) begin
      wr(nums[$unsigned($random(seed)) % 4], $random(seed));
      check_all();
      ev();
    end
    $display("test random traffic done");
    rst_n = 1'b0;
    m_cfg = 32'h0;
    m_base = 32'h0;
    #1;
    check_all();
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    ev();
    $display("test second reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
